//--- rtl/sbt_timer.v
// Sixteen-bit timer core with double buffering and waveform outputs
//
// Added by the designer: strobed register access and the placing of the registers.
`include "sbt_defines.vh"
module sbt_timer #(
  parameter W = 16
) (
  input  wire          CLOCK,
  input  wire          RST_N,
  input  wire [4:0]    ADDR,
  input  wire [15:0]   WDATA,
  input  wire          WR,
  input  wire          RD,
  output reg  [15:0]   RDATA,
  input  wire          EVENT_IN,
  output wire [2:0]    WAVE_OUT,
  output wire [2:0]    WAVE_OE
);
  reg  [3:0]   control_reg_a_q;
  reg  [6:0]   control_reg_b_q;
  reg          split_q;
  reg  [1:0]   control_reg_e_q;
  reg  [2:0]   event_control_reg_q;
  reg  [4:0]   flags_q;
  reg  [W-1:0] cnt_q;
  reg  [W-1:0] per_q;
  reg  [W-1:0] cycle_length_staging_q;
  reg          cycle_staging_valid_q;
  reg  [W-1:0] cmp_q [0:2];
  reg  [W-1:0] cmpbuf_q [0:2];
  reg  [2:0]   cmpbv_q;
  reg  [2:0]   wo_q;
  reg  [9:0]   pre_q;
  reg  [2:0]   ev_sync_q;
  reg          ev_seen_q;

  wire       en     = control_reg_a_q[`SBT_CA_EN];
  wire [2:0] ps     = control_reg_a_q[`SBT_CA_PS_LO+2:`SBT_CA_PS_LO];
  wire [1:0] wg     = control_reg_b_q[1:0];
  wire       ev_cnt = event_control_reg_q[`SBT_EV_CNT];
  wire [1:0] ev_act = event_control_reg_q[2:1];
  wire       down   = control_reg_e_q[`SBT_CE_DIR];
  wire       hold   = control_reg_e_q[`SBT_CE_HOLD];

  // Event pin from another domain: three stages, edge once last two agree
  wire ev_level = ev_sync_q[1] & ev_sync_q[2];
  wire ev_rise  = ev_level & ~ev_seen_q;

  // Prescaler taps 1,2,4,8,16,64,256,1024
  reg  [9:0] pre_mask;
  always @* begin
    case (ps)
      3'h0:    pre_mask = 10'h000;
      3'h1:    pre_mask = 10'h001;
      3'h2:    pre_mask = 10'h003;
      3'h3:    pre_mask = 10'h007;
      3'h4:    pre_mask = 10'h00f;
      3'h5:    pre_mask = 10'h03f;
      3'h6:    pre_mask = 10'h0ff;
      default: pre_mask = 10'h3ff;
    endcase
  end
  wire clk_tick = en & ((pre_q & pre_mask) == pre_mask);
  // Event counting replaces the clock tick
  wire tick = en & (ev_cnt ? (ev_act == `SBT_EA_COUNT) & ev_rise : clk_tick);

  // Direction may come from the event level
  wire eff_down = (ev_cnt && ev_act == `SBT_EA_DIR) ? ev_level : down;
  wire restart  = en & ev_cnt & (ev_act == `SBT_EA_RESTART) & ev_rise;

  // Split halves: low byte and high byte each count down independently
  wire [7:0] lcnt = cnt_q[7:0];
  wire [7:0] hcnt = cnt_q[15:8];

  // Ceiling comes from compare zero in frequency mode
  wire [W-1:0] top    = (wg == `SBT_WG_FRQ) ? cmp_q[0] : per_q;
  wire         at_top = (cnt_q == top);
  wire         at_bot = (cnt_q == {W{1'b0}});
  wire         ds     = (wg == `SBT_WG_DS);
  reg          ds_down_q;
  wire         cur_down = ds ? ds_down_q : eff_down;

  // Transfer point: count_zero_point for dual slope, otherwise the wrap or reload point
  wire wrap   = tick & ~split_q & ~ds & ~cur_down & at_top;
  wire reload = tick & ~split_q & ~ds & cur_down & at_bot;
  wire ds_bot = tick & ~split_q & ds & ds_down_q & (cnt_q == {{W-1{1'b0}}, 1'b1});
  wire upd    = (wrap | reload | ds_bot) & ~hold;

  wire wr_cnt  = WR & (ADDR == `SBT_A_CNT);
  wire wr_per  = WR & (ADDR == `SBT_A_PER);
  wire wr_pbuf = WR & (ADDR == `SBT_A_CYCLE_LENGTH_STAGING);

  reg [W-1:0] cnt_d;
  always @* begin
    cnt_d = cnt_q;
    if (restart) begin
      cnt_d = {W{1'b0}};
    end else if (tick && split_q) begin
      cnt_d[7:0]  = (lcnt == 8'h00) ? per_q[7:0] : lcnt - 8'h01;
      cnt_d[15:8] = (hcnt == 8'h00) ? per_q[15:8] : hcnt - 8'h01;
    end else if (tick && ds) begin
      cnt_d = ds_down_q ? cnt_q - {{W-1{1'b0}}, 1'b1} : cnt_q + {{W-1{1'b0}}, 1'b1};
    end else if (wrap) begin
      cnt_d = {W{1'b0}};
    end else if (reload) begin
      cnt_d = top;
    end else if (tick) begin
      cnt_d = cur_down ? cnt_q - {{W-1{1'b0}}, 1'b1} : cnt_q + {{W-1{1'b0}}, 1'b1};
    end
    if (wr_cnt) begin
      cnt_d = WDATA;
    end
  end

  // Match per channel; flag rises the cycle after equality
  wire [2:0] match;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_ch
      assign match[g] = en & ~split_q & (cnt_q == cmp_q[g]);
      wire wr_cmp  = WR & (ADDR == `SBT_A_MATCH_VALUE_ZERO + g);
      wire wr_cbuf = WR & (ADDR == `SBT_A_CMPBUF0 + g);
      always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
          cmp_q[g]    <= {W{1'b0}};
          cmpbuf_q[g] <= {W{1'b0}};
          cmpbv_q[g]  <= 1'b0;
          wo_q[g]     <= 1'b0;
        end else begin
          if (wr_cmp) begin
            cmp_q[g] <= WDATA;
          end else if (upd && cmpbv_q[g]) begin
            cmp_q[g] <= cmpbuf_q[g];
          end
          if (wr_cbuf) begin
            cmpbuf_q[g] <= WDATA;
          end
          // Staging write wins over a same-cycle transfer
          if (wr_cbuf) begin
            cmpbv_q[g] <= 1'b1;
          end else if (upd) begin
            cmpbv_q[g] <= 1'b0;
          end
          // Only frequency, single-slope and dual-slope PWM shapes are modelled
          if (restart) begin
            wo_q[g] <= 1'b0;
          end else if (wg == `SBT_WG_FRQ) begin
            if (match[g] && tick) begin
              wo_q[g] <= ~wo_q[g];
            end
          end else if (wg != `SBT_WG_NORMAL) begin
            if (tick && (ds ? (cnt_q == {W{1'b0}}) : (wrap | reload))) begin
              wo_q[g] <= 1'b1;
            end else if (tick && match[g]) begin
              wo_q[g] <= ds ? ds_down_q : 1'b0;
            end
          end
        end
      end
      // Pin override needs a mode, clock counting and channel enable
      assign WAVE_OE[g]  = (wg != `SBT_WG_NORMAL) & ~ev_cnt & control_reg_b_q[`SBT_CB_CEN_LO+g];
      assign WAVE_OUT[g] = wo_q[g] & WAVE_OE[g];
    end
  endgenerate

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      control_reg_a_q   <= 4'h0;
      control_reg_b_q   <= 7'h00;
      split_q   <= 1'b0;
      control_reg_e_q   <= 2'h0;
      event_control_reg_q  <= 3'h0;
      flags_q   <= 5'h00;
      cnt_q     <= {W{1'b0}};
      per_q     <= `SBT_PER_RST;
      cycle_length_staging_q  <= `SBT_PER_RST;
      cycle_staging_valid_q   <= 1'b0;
      pre_q     <= 10'h000;
      ev_sync_q <= 3'h0;
      ev_seen_q <= 1'b0;
      ds_down_q <= 1'b0;
      RDATA     <= 16'h0000;
    end else begin
      ev_sync_q <= {ev_sync_q[1:0], EVENT_IN};
      ev_seen_q <= ev_level;
      pre_q     <= en ? pre_q + 10'h001 : 10'h000;
      cnt_q     <= cnt_d;
      if (restart) begin
        ds_down_q <= 1'b0;
      end else if (tick && ds && !ds_down_q && at_top) begin
        ds_down_q <= 1'b1;
      end else if (ds_bot) begin
        ds_down_q <= 1'b0;
      end
      if (WR) begin
        case (ADDR)
          `SBT_A_CONTROL_REG_A:  control_reg_a_q  <= WDATA[3:0];
          `SBT_A_CONTROL_REG_B:  control_reg_b_q  <= WDATA[6:0];
          `SBT_A_CTRLD:  split_q  <= WDATA[`SBT_CD_SPLIT];
          `SBT_A_CONTROL_REG_E:  control_reg_e_q  <= WDATA[1:0];
          `SBT_A_EVENT_CONTROL_REG: event_control_reg_q <= WDATA[2:0];
          default: ;
        endcase
      end
      if (wr_per) begin
        per_q <= WDATA;
      end else if (upd && cycle_staging_valid_q) begin
        per_q <= cycle_length_staging_q;
      end
      if (wr_pbuf) begin
        cycle_length_staging_q <= WDATA;
      end
      if (wr_pbuf) begin
        cycle_staging_valid_q <= 1'b1;
      end else if (upd) begin
        cycle_staging_valid_q <= 1'b0;
      end
      // Flags: a hardware set beats a same-cycle write-one clear
      flags_q <= (flags_q & ~((WR && ADDR == `SBT_A_FLAGS) ? WDATA[4:0] : 5'h00))
               | {tick & split_q & (hcnt == 8'h00),
                  match,
                  wrap | reload | ds_bot | (tick & split_q & (lcnt == 8'h00))};
      RDATA <= 16'h0000;
      if (RD) begin
        case (ADDR)
          `SBT_A_CONTROL_REG_A:   RDATA <= {12'h000, control_reg_a_q};
          `SBT_A_CONTROL_REG_B:   RDATA <= {9'h000, control_reg_b_q};
          `SBT_A_CTRLD:   RDATA <= {15'h0000, split_q};
          `SBT_A_CONTROL_REG_E:   RDATA <= {14'h0000, control_reg_e_q};
          `SBT_A_CONTROL_REG_F:   RDATA <= {12'h000, cmpbv_q, cycle_staging_valid_q};
          `SBT_A_EVENT_CONTROL_REG:  RDATA <= {13'h0000, event_control_reg_q};
          `SBT_A_FLAGS:   RDATA <= {11'h000, flags_q};
          `SBT_A_CNT:     RDATA <= cnt_q;
          `SBT_A_PER:     RDATA <= per_q;
          `SBT_A_MATCH_VALUE_ZERO:    RDATA <= cmp_q[0];
          `SBT_A_CMP1:    RDATA <= cmp_q[1];
          `SBT_A_CMP2:    RDATA <= cmp_q[2];
          `SBT_A_CYCLE_LENGTH_STAGING:  RDATA <= cycle_length_staging_q;
          `SBT_A_CMPBUF0: RDATA <= cmpbuf_q[0];
          `SBT_A_CMPBUF1: RDATA <= cmpbuf_q[1];
          `SBT_A_CMPBUF2: RDATA <= cmpbuf_q[2];
          default:        RDATA <= 16'h0000;
        endcase
      end
    end
  end
endmodule // sbt_timer

//--- rtl/sbt_defines.vh
// Constants and register map of the sixteen-bit timer core
// Functional notes
// - Counter, period, compares and staging are 16-bit
// - Count_zero_point is zero, ceiling is sequence top
// - Transfer at count_zero_point/ceiling unless hold bit set
// - Count one per prescaled tick, chosen direction
// - Up at ceiling wraps to zero next tick
// - Down at count_zero_point reloads cycle length
// - Counter write immediate, beats count/clear/reload
// - Direction writable while running
// - Enable starts counting at prescaler rate
// - Event select counts events instead of ticks
// - Period and compares have staging plus valid
// - Valid set on staging write, cleared on transfer
// - Working and staging compares both writable
// - Direct period write immediate, may wrap at max
// - Staged period loads only at transfer
// - Staged compares load only at transfer
// - Compare match sets channel flag next cycle
// - Waveform drives pin only when mode, no events, enabled
// - Frequency mode period from compare zero
// - Frequency mode toggles output on each match
// - Compare zero of zero gives half clock
// - Split mode: two 8-bit counters
// - Events may set direction or restart counter; no ticks reach the counter under either action
`ifndef SBT_DEFINES_VH
`define SBT_DEFINES_VH
`define SBT_A_CONTROL_REG_A    5'h00
`define SBT_A_CONTROL_REG_B    5'h01
`define SBT_A_CTRLD    5'h02
`define SBT_A_CONTROL_REG_E    5'h03
`define SBT_A_CONTROL_REG_F    5'h04
`define SBT_A_EVENT_CONTROL_REG   5'h05
`define SBT_A_FLAGS    5'h06
`define SBT_A_CNT      5'h07
`define SBT_A_PER      5'h08
`define SBT_A_MATCH_VALUE_ZERO     5'h09
`define SBT_A_CMP1     5'h0a
`define SBT_A_CMP2     5'h0b
`define SBT_A_CYCLE_LENGTH_STAGING   5'h0c
`define SBT_A_CMPBUF0  5'h0d
`define SBT_A_CMPBUF1  5'h0e
`define SBT_A_CMPBUF2  5'h0f
// Control A: bit0 enable, bits3:1 prescale select
`define SBT_CA_EN      0
`define SBT_CA_PS_LO   1
// Control B: bits1:0 waveform select, bits6:4 channel output enables
`define SBT_CB_CEN_LO  4
`define SBT_WG_NORMAL  2'h0
`define SBT_WG_FRQ     2'h1
`define SBT_WG_SS      2'h2
`define SBT_WG_DS      2'h3
// Control D: bit0 split
`define SBT_CD_SPLIT   0
// Control E: bit0 direction (1 = down), bit1 hold transfer
`define SBT_CE_DIR     0
`define SBT_CE_HOLD    1
// Event control: bit0 count events, bits2:1 action
`define SBT_EV_CNT     0
`define SBT_EA_COUNT   2'h0
`define SBT_EA_DIR     2'h1
`define SBT_EA_RESTART 2'h2
// Flags: bit0 overflow, bits3:1 compare matches, bit4 high underflow
`define SBT_FL_OVF     0
`define SBT_FL_HUNF    4
`define SBT_PER_RST    16'hffff
`endif

//--- sim/sbt_timer_sva.sv
// Port checker for the sixteen-bit timer core
module sbt_timer_sva #(
  parameter W = 16
) (
  input wire        CLOCK,
  input wire        RST_N,
  input wire [4:0]  ADDR,
  input wire [15:0] WDATA,
  input wire        WR,
  input wire        RD,
  input wire [15:0] RDATA,
  input wire        EVENT_IN,
  input wire [2:0]  WAVE_OUT,
  input wire [2:0]  WAVE_OE
);
  reg  [6:0] cb_q;
  reg  [3:0] ca_q;
  reg  [2:0] ev_q;
  reg  [2:0] run_q;
  reg        cmp0z_q;
  reg        cnt0_q;
  wire       frequency_mode;
  assign frequency_mode = cb_q[1:0] == 2'h1 && cb_q[4] && ca_q == 4'h1 && cmp0z_q && ev_q == 3'h0;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // Shadows of direct writes only; staged compare zero drops the knowledge
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      cb_q    <= 7'h00;
      ca_q    <= 4'h0;
      ev_q    <= 3'h0;
      cmp0z_q <= 1'b0;
      cnt0_q  <= 1'b0;
      run_q   <= 3'h0;
    end else begin
      if (WR && ADDR == 5'h01) cb_q <= WDATA[6:0];
      if (WR && ADDR == 5'h00) ca_q <= WDATA[3:0];
      if (WR && ADDR == 5'h05) ev_q <= WDATA[2:0];
      if (WR && ADDR == 5'h09) cmp0z_q <= WDATA == 16'h0000;
      else if (WR && ADDR == 5'h0d) cmp0z_q <= 1'b0;
      if (WR && ADDR == 5'h07) cnt0_q <= WDATA == 16'h0000;
      else if (ca_q[0] && !frequency_mode) cnt0_q <= 1'b0;
      run_q <= (frequency_mode && cnt0_q) ? ((run_q == 3'h5) ? run_q : run_q + 3'h1) : 3'h0;
    end
  end
  oe_gate_a:
    assert property ((WAVE_OUT & ~WAVE_OE) == 3'h0) else $error("wave out high without enable");
  oe_map_a:
    assert property (WAVE_OE == ((cb_q[1:0] != 2'h0 && !ev_q[0]) ? cb_q[6:4] : 3'h0))
      else $error("output enable mismatch");
  cnt_write_a:
    assert property ((WR && ADDR == 5'h07) ##1 (RD && ADDR == 5'h07) |=> RDATA == $past(WDATA, 2))
      else $error("count write not immediate");
  dir_read_a:
    assert property ((WR && ADDR == 5'h03) ##1 (RD && ADDR == 5'h03)
      |=> (RDATA & 16'h0003) == ($past(WDATA, 2) & 16'h0003)) else $error("direction lost");
  per_read_a:
    assert property ((WR && ADDR == 5'h08) ##1 (RD && ADDR == 5'h08) |=> RDATA == $past(WDATA, 2))
      else $error("direct period write not immediate");
  cmp_read_a:
    assert property ((WR && ADDR == 5'h0a) ##1 (RD && ADDR == 5'h0a) |=> RDATA == $past(WDATA, 2))
      else $error("direct compare write not immediate");
  bv_set_a:
    assert property ((WR && ADDR == 5'h0c) ##1 (RD && ADDR == 5'h04) |=> RDATA[0])
      else $error("staging valid not set");
  frq_half_a:
    assert property (run_q == 3'h5 && frequency_mode |-> WAVE_OUT[0] != $past(WAVE_OUT[0]))
      else $error("frequency output not toggling");
  cover property (run_q == 3'h5);
  cover property ((WR && ADDR == 5'h0c) ##1 (RD && ADDR == 5'h04));
  cover property (WAVE_OE != 3'h0);
endmodule // sbt_timer_sva
bind sbt_timer sbt_timer_sva #(.W(W)) u_sva (.CLOCK(CLOCK), .RST_N(RST_N), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .EVENT_IN(EVENT_IN), .WAVE_OUT(WAVE_OUT),
  .WAVE_OE(WAVE_OE));

//--- sim/test_sixteen_bit_timer_core.sv
// Self-checking testbench for the sixteen-bit timer core
module test_sixteen_bit_timer_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLOCK;
  logic        RST_N;
  logic [4:0]  ADDR;
  logic [15:0] WDATA;
  logic        WR;
  logic        RD;
  logic        EVENT_IN;
  wire  [15:0] RDATA;
  wire  [2:0]  WAVE_OUT;
  wire  [2:0]  WAVE_OE;
  int          fail_count;
  int          num_checks;
  logic [15:0] v;
  logic        w;
  sbt_timer #(.W(16)) uut (.CLOCK(CLOCK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .EVENT_IN(EVENT_IN), .WAVE_OUT(WAVE_OUT), .WAVE_OE(WAVE_OE));
  initial begin
    CLOCK = 1'b0;
    forever #4 CLOCK = ~CLOCK;
  end
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // Strobes are left up; the next task lowers them, so no signal is set twice per step
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    RD <= 1'b0;
    @(posedge CLOCK);
  endtask
  task automatic rd(input logic [4:0] a);
    ADDR <= a;
    RD <= 1'b1;
    WR <= 1'b0;
    @(posedge CLOCK);
    RD <= 1'b0;
    @(posedge CLOCK);
    v = RDATA;
  endtask
  task automatic idle(input int n);
    WR <= 1'b0;
    RD <= 1'b0;
    repeat (n) @(posedge CLOCK);
  endtask
  task automatic t_reset;
    rd(5'h08); chk("per_rst", v, 16'hffff);
    rd(5'h04); chk("bv_rst", v, 16'h0000);
    wr(5'h10, 16'h1234); rd(5'h10); chk("unmapped", v, 16'h0000);
  endtask
  task automatic t_count;
    wr(5'h08, 16'h0005); wr(5'h07, 16'h0000); wr(5'h00, 16'h0001); idle(40);
    wr(5'h07, 16'h0003); rd(5'h07); wr(5'h00, 16'h0000);
    rd(5'h07); chk("up_wrap", {15'h0, v <= 16'h0005}, 16'h0001);
    rd(5'h06); chk("ovf_up", v & 16'h0001, 16'h0001);
    wr(5'h06, 16'h001f); rd(5'h06); chk("flag_clr", v, 16'h0000);
    wr(5'h08, 16'hffff); wr(5'h07, 16'h0000); wr(5'h00, 16'h000f); idle(100);
    wr(5'h00, 16'h0000); rd(5'h07); chk("ps_slow", {15'h0, v <= 16'h0001}, 16'h0001);
    wr(5'h07, 16'h0000); wr(5'h00, 16'h0001); idle(50); wr(5'h00, 16'h0000); rd(5'h07);
    chk("ps_one", {15'h0, v >= 16'd45 && v <= 16'd52}, 16'h0001);
  endtask
  task automatic t_down;
    wr(5'h08, 16'h0005); wr(5'h07, 16'h0002); wr(5'h03, 16'h0001); rd(5'h03);
    wr(5'h00, 16'h0001); idle(30); wr(5'h00, 16'h0000);
    rd(5'h07); chk("down_rld", {15'h0, v <= 16'h0005}, 16'h0001);
    rd(5'h06); chk("ovf_dn", v & 16'h0001, 16'h0001);
    wr(5'h03, 16'h0000); wr(5'h06, 16'h001f);
  endtask
  task automatic t_wrap;
    wr(5'h07, 16'h000a); wr(5'h08, 16'h0003); rd(5'h08); wr(5'h00, 16'h0001); idle(20);
    wr(5'h00, 16'h0000); rd(5'h07); chk("late_top", {15'h0, v > 16'h000a}, 16'h0001);
  endtask
  task automatic t_buffer;
    wr(5'h08, 16'h0005); wr(5'h07, 16'h0000); wr(5'h03, 16'h0002);
    wr(5'h0c, 16'h0007); rd(5'h04); wr(5'h0e, 16'h0002); wr(5'h0a, 16'h0004); rd(5'h0a);
    wr(5'h00, 16'h0001); idle(30);
    rd(5'h08); chk("hold_per", v, 16'h0005);
    rd(5'h04); chk("bv_held", v, 16'h0005);
    wr(5'h03, 16'h0000); idle(30); wr(5'h00, 16'h0000);
    rd(5'h08); chk("xfer_per", v, 16'h0007);
    rd(5'h0a); chk("xfer_cmp", v, 16'h0002);
    rd(5'h04); chk("bv_clr", v, 16'h0000);
    rd(5'h06); chk("cmp_flag", v & 16'h0004, 16'h0004);
  endtask
  task automatic t_event;
    // Compare zero sets the top in frequency mode, so keep it out of reach
    wr(5'h09, 16'hffff);
    wr(5'h08, 16'hffff); wr(5'h07, 16'h0000); wr(5'h05, 16'h0001); wr(5'h01, 16'h0071);
    wr(5'h00, 16'h0001);
    repeat (3) begin
      EVENT_IN <= 1'b1; idle(4); EVENT_IN <= 1'b0; idle(4);
    end
    idle(8); chk("oe_evt", {13'h0, WAVE_OE}, 16'h0000);
    wr(5'h00, 16'h0000); rd(5'h07); chk("evt_cnt", v, 16'h0003);
    wr(5'h05, 16'h0000);
  endtask
  task automatic t_split;
    wr(5'h06, 16'h001f); wr(5'h02, 16'h0001); wr(5'h08, 16'h0302); wr(5'h07, 16'h0000);
    wr(5'h00, 16'h0001); idle(20); wr(5'h00, 16'h0000);
    rd(5'h06); chk("split_unf", v & 16'h0011, 16'h0011);
    rd(5'h07); chk("split_cnt", {15'h0, v[15:8] <= 8'h03 && v[7:0] <= 8'h02}, 16'h0001);
    wr(5'h02, 16'h0000); wr(5'h06, 16'h001f);
  endtask
  task automatic t_frq;
    wr(5'h07, 16'h0000); wr(5'h09, 16'h0000); wr(5'h00, 16'h0001); idle(8);
    w = WAVE_OUT[0]; idle(1);
    chk("frq_tog", {15'h0, WAVE_OUT[0]}, {15'h0, ~w});
    chk("oe_frq", {13'h0, WAVE_OE}, 16'h0007);
    wr(5'h00, 16'h0000); wr(5'h09, 16'h0002); wr(5'h07, 16'h0000); wr(5'h00, 16'h0001);
    idle(20); wr(5'h00, 16'h0000);
    rd(5'h07); chk("frq_top", {15'h0, v <= 16'h0002}, 16'h0001);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    {RST_N, WR, RD, EVENT_IN, ADDR, WDATA} = '0;
    repeat (2) @(posedge CLOCK);
    RST_N <= 1'b1;
    t_reset; t_count; t_down; t_wrap; t_buffer; t_event; t_split; t_frq;
    idle(2);
    close_out;
  end
  // Full run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge CLOCK);
    fail_count++;
    close_out;
  end
endmodule // test_sixteen_bit_timer_core
